// ==== scpp_io_match.sv ====
`timescale 1ns/1ps
module scpp_io_match
  import scpp_pkg::*;
#(
  parameter int ADDR_W = SCPP_IO_ADDR_W,
  parameter int SPAN = SCPP_IO_SPAN
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Host I/O cycle
  input wire logic io_wr_i,
  input wire logic [ADDR_W-1:0] io_addr_i,
  input wire logic [ADDR_W-1:0] io_base_i,
  // Match pulse, one cycle after the write
  output logic match_o
);
  typedef struct packed {
    logic match;
  } scpp_match_st_t;

  scpp_match_st_t s_q;
  scpp_match_st_t s_d;
  logic [ADDR_W:0] offs;

  always_comb begin
    offs = {1'b0, io_addr_i} - {1'b0, io_base_i};
    s_d.match = io_wr_i && !offs[ADDR_W] && (offs < (ADDR_W + 1)'(SPAN));
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign match_o = s_q.match;
endmodule : scpp_io_match

// ==== scpp_isa_host.sv ====
`timescale 1ns/1ps
module scpp_isa_host
  import scpp_pkg::*;
(
  // Host I/O cycle
  input wire logic clk_i,
  output logic io_wr_o,
  output logic [SCPP_IO_ADDR_W-1:0] io_addr_o
);
  initial begin
    io_wr_o = 1'b0;
    io_addr_o = 16'h5a5a;
  end
  // A released address bus shows no stale value
  task automatic io_write(input logic [SCPP_IO_ADDR_W-1:0] a);
    @(posedge clk_i);
    io_wr_o <= 1'b1;
    io_addr_o <= a;
    @(posedge clk_i);
    io_wr_o <= 1'b0;
    io_addr_o <= ~a;
  endtask : io_write
endmodule : scpp_isa_host

// ==== scpp_pkg.sv ====
package scpp_pkg;
  localparam int SCPP_DATA_W = 16;
  localparam int SCPP_ADDR_W = 8;
  localparam int SCPP_IO_ADDR_W = 16;

  // Register offsets
  localparam logic [7:0] SCPP_OFF_SELF_CONTROL = 8'h00;
  localparam logic [7:0] SCPP_OFF_MODE_STATUS = 8'h04;

  // Self-control field positions
  localparam int SCPP_BIT_CHIP_RESET = 6;
  localparam int SCPP_BIT_SW_SUSPEND = 8;
  localparam int SCPP_BIT_SLEEP_EN = 9;
  localparam int SCPP_BIT_STANDBY_SEL = 10;
  localparam int SCPP_BIT_AUX0_SEL = 12;
  localparam int SCPP_BIT_AUX1_SEL = 13;
  localparam int SCPP_BIT_AUX0_LEVEL = 14;
  localparam int SCPP_BIT_AUX1_LEVEL = 15;

  // Identifier field, reset value and writable control bits
  localparam logic [15:0] SCPP_ID_FIELD = 16'h0015;
  localparam logic [15:0] SCPP_SELF_CONTROL_RESET = 16'h0015;
  localparam logic [15:0] SCPP_CTRL_MASK = 16'hf700;

  // Mode status field positions
  localparam int SCPP_ST_CHIP_RESET = 0;
  localparam int SCPP_ST_SW_SUSPEND = 1;
  localparam int SCPP_ST_HW_STANDBY = 2;
  localparam int SCPP_ST_HW_SUSPEND = 3;

  // Chip-wide reset pulse length
  localparam int SCPP_CLK_MHZ = 250;
  localparam int SCPP_CHIP_RESET_NS = 100;
  localparam int SCPP_CHIP_RESET_CYC = (SCPP_CHIP_RESET_NS * SCPP_CLK_MHZ + 999) / 1000;
  localparam int SCPP_RST_CNT_W = 8;

  // Default span of the device's I/O window, in bytes
  localparam int SCPP_IO_SPAN = 16;
endpackage : scpp_pkg

// ==== scpp_self_control.sv ====
`timescale 1ns/1ps
// Contract
// R1: Writing one to reset bit starts chip reset now; bit always reads back zero.
// R2: Software suspend bit enters suspend; partial reset spares base address and this register.
// R3: No frame transmission or reception while in software suspend.
// R4: Host I/O write inside device I/O space ends software suspend.
// R5: Aux1 select clear gives receiver bus activity; set follows aux1 level bit.
// R6: Aux0 select set: active-low aux0 pin low when level set, high when clear.
// R7: Aux0 select clear: aux0 level bit is ignored entirely.
// R8: Without EEPROM, reset value has control bits clear and identifier 010101.
// R9: Detected EEPROM may supply the initial control-bit values after reset.
// R10: Enabled sleep pin low enters standby if selected, else hardware suspend.
module scpp_self_control
  import scpp_pkg::*;
#(
  parameter int IO_SPAN = SCPP_IO_SPAN,
  parameter int CHIP_RESET_CYC = SCPP_CHIP_RESET_CYC
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  // Register port
  input wire logic [SCPP_ADDR_W-1:0] ADDR_I,
  input wire logic [SCPP_DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [SCPP_DATA_W-1:0] RDATA_O,
  // Host I/O cycles seen on the ISA side
  input wire logic IO_WR_I,
  input wire logic [SCPP_IO_ADDR_W-1:0] IO_ADDR_I,
  input wire logic [SCPP_IO_ADDR_W-1:0] IO_BASE_I,
  // EEPROM preset
  input wire logic EE_LOAD_I,
  input wire logic EE_PRESENT_I,
  input wire logic [SCPP_DATA_W-1:0] EE_VALUE_I,
  // Pins and status inputs
  input wire logic SLEEP_N_I,
  input wire logic RX_BUS_ACTIVE_I,
  input wire logic AUX0_DEFAULT_N_I,
  // Power and reset controls
  output logic CHIP_RESET_O,
  output logic PARTIAL_RESET_O,
  output logic TXRX_INHIBIT_O,
  output logic HW_STANDBY_O,
  output logic HW_SUSPEND_O,
  // Auxiliary pins
  output logic AUX_OUT0_PIN_N_O,
  output logic AUX_OUT1_PIN_O
);
  typedef enum logic [1:0] {
    SCPP_RUN = 2'b00,
    SCPP_CHIP_RST = 2'b01,
    SCPP_SW_SUSP = 2'b10
  } scpp_mode_t;

  typedef struct packed {
    scpp_mode_t mode;
    logic [SCPP_RST_CNT_W-1:0] rst_cnt;
    logic [SCPP_DATA_W-1:0] ctrl;
    logic [SCPP_DATA_W-1:0] rdata;
    logic chip_reset;
    logic partial_reset;
    logic inhibit;
    logic hw_standby;
    logic hw_suspend;
    logic aux0_n;
    logic aux1;
  } scpp_state_t;

  // Idle view after power-up: no reset or suspend running, aux0 pin released high
  localparam scpp_state_t init_state = '{
    mode: SCPP_RUN,
    rst_cnt: '0,
    ctrl: SCPP_SELF_CONTROL_RESET,
    rdata: '0,
    chip_reset: 1'b0,
    partial_reset: 1'b0,
    inhibit: 1'b0,
    hw_standby: 1'b0,
    hw_suspend: 1'b0,
    aux0_n: 1'b1,
    aux1: 1'b0
  };

  scpp_state_t s_q;
  scpp_state_t s_d;
  logic io_match;
  logic wr_ctrl;
  logic wr_reset;
  logic wr_suspend;
  logic sleep_req;

  function automatic logic [SCPP_DATA_W-1:0] scpp_ctrl_view(input logic [SCPP_DATA_W-1:0] v);
    scpp_ctrl_view = (v & SCPP_CTRL_MASK) | SCPP_ID_FIELD;
  endfunction : scpp_ctrl_view

  function automatic logic [SCPP_DATA_W-1:0] scpp_status_view(input logic chip_rst, input logic sw_susp,
                                                                input logic standby, input logic hw_susp);
    scpp_status_view = '0;
    scpp_status_view[SCPP_ST_CHIP_RESET] = chip_rst;
    scpp_status_view[SCPP_ST_SW_SUSPEND] = sw_susp;
    scpp_status_view[SCPP_ST_HW_STANDBY] = standby;
    scpp_status_view[SCPP_ST_HW_SUSPEND] = hw_susp;
  endfunction : scpp_status_view

  // Both aux pins share this mux, so their select bits behave alike
  function automatic logic scpp_pin_pick(input logic sel, input logic level, input logic dflt);
    scpp_pin_pick = sel ? level : dflt;
  endfunction : scpp_pin_pick

  scpp_io_match #(
    .ADDR_W(SCPP_IO_ADDR_W),
    .SPAN(IO_SPAN)
  ) u_io_match (
    .clk_i(REF_CLK_I),
    .reset_n_i(RESET_N_I),
    .io_wr_i(IO_WR_I),
    .io_addr_i(IO_ADDR_I),
    .io_base_i(IO_BASE_I),
    .match_o(io_match)
  );

  always_comb begin
    s_d = s_q;
    wr_ctrl = WR_I && (ADDR_I == SCPP_OFF_SELF_CONTROL);
    wr_reset = wr_ctrl && WDATA_I[SCPP_BIT_CHIP_RESET];
    wr_suspend = wr_ctrl && WDATA_I[SCPP_BIT_SW_SUSPEND];
    s_d.rdata = '0;

    // The stored copy never keeps the act-once bit; it reads as zero
    if (wr_ctrl) begin
      s_d.ctrl = scpp_ctrl_view(WDATA_I); // R1
    end

    unique case (s_q.mode)
      SCPP_RUN: begin
        if (wr_reset) begin
          s_d.mode = SCPP_CHIP_RST; // R1
          s_d.rst_cnt = SCPP_RST_CNT_W'(CHIP_RESET_CYC - 1);
        end else if (wr_suspend) begin
          s_d.mode = SCPP_SW_SUSP; // R2
        end
      end
      SCPP_CHIP_RST: begin
        // Chip reset returns this register to its default too
        s_d.ctrl = SCPP_SELF_CONTROL_RESET; // R1 R8
        if (s_q.rst_cnt == '0) begin
          s_d.mode = SCPP_RUN;
        end else begin
          s_d.rst_cnt = s_q.rst_cnt - 1'b1;
        end
      end
      SCPP_SW_SUSP: begin
        if (wr_reset) begin
          s_d.mode = SCPP_CHIP_RST; // R1
          s_d.rst_cnt = SCPP_RST_CNT_W'(CHIP_RESET_CYC - 1);
        end else if (wr_ctrl) begin
          // A write to this register is itself an I/O write, so it wakes unless it sets the suspend bit again
          s_d.mode = wr_suspend ? SCPP_SW_SUSP : SCPP_RUN; // R4
        end else if (io_match) begin
          s_d.mode = SCPP_RUN; // R4
          s_d.ctrl[SCPP_BIT_SW_SUSPEND] = 1'b0; // R4
        end
      end
      default: begin
        s_d.mode = SCPP_RUN;
      end
    endcase

    // EEPROM preset only in run mode, never during a chip reset or software suspend; a software write wins
    if (EE_LOAD_I && EE_PRESENT_I && !wr_ctrl && s_q.mode == SCPP_RUN) begin
      s_d.ctrl = scpp_ctrl_view(EE_VALUE_I); // R9
      if (EE_VALUE_I[SCPP_BIT_SW_SUSPEND]) begin
        s_d.mode = SCPP_SW_SUSP;
      end
    end

    if (RD_I) begin
      case (ADDR_I)
        SCPP_OFF_SELF_CONTROL: begin
          s_d.rdata = s_q.ctrl; // R1 R8
        end
        SCPP_OFF_MODE_STATUS: begin
          s_d.rdata = scpp_status_view(s_q.chip_reset, s_q.partial_reset, s_q.hw_standby, s_q.hw_suspend);
        end
        default: begin
          // Unmapped offsets read as zero
          s_d.rdata = '0;
        end
      endcase
    end

    s_d.chip_reset = (s_d.mode == SCPP_CHIP_RST); // R1
    s_d.partial_reset = (s_d.mode == SCPP_SW_SUSP); // R2
    s_d.inhibit = (s_d.mode != SCPP_RUN); // R3

    sleep_req = s_q.ctrl[SCPP_BIT_SLEEP_EN] && !SLEEP_N_I; // R10
    s_d.hw_standby = sleep_req && s_q.ctrl[SCPP_BIT_STANDBY_SEL]; // R10
    s_d.hw_suspend = sleep_req && !s_q.ctrl[SCPP_BIT_STANDBY_SEL]; // R10

    // With aux0 select set, level bit set pulls the active-low aux0 pin low
    s_d.aux0_n = scpp_pin_pick(s_q.ctrl[SCPP_BIT_AUX0_SEL], !s_q.ctrl[SCPP_BIT_AUX0_LEVEL], // R6
                               AUX0_DEFAULT_N_I); // R7
    s_d.aux1 = scpp_pin_pick(s_q.ctrl[SCPP_BIT_AUX1_SEL], s_q.ctrl[SCPP_BIT_AUX1_LEVEL], // R5
                             RX_BUS_ACTIVE_I);
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s_q <= init_state; // R8
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA_O = s_q.rdata;
  assign CHIP_RESET_O = s_q.chip_reset;
  assign PARTIAL_RESET_O = s_q.partial_reset;
  assign TXRX_INHIBIT_O = s_q.inhibit;
  assign HW_STANDBY_O = s_q.hw_standby;
  assign HW_SUSPEND_O = s_q.hw_suspend;
  assign AUX_OUT0_PIN_N_O = s_q.aux0_n;
  assign AUX_OUT1_PIN_O = s_q.aux1;
endmodule : scpp_self_control

// ==== scpp_self_control_asserts.sv ====
`timescale 1ns/1ps
module scpp_sc_asserts
  import scpp_pkg::*;
#(parameter int IO_SPAN = SCPP_IO_SPAN) (
  // Clock, reset and register writes
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic WR_I,
  input wire logic [SCPP_ADDR_W-1:0] ADDR_I,
  input wire logic [SCPP_DATA_W-1:0] WDATA_I,
  // Host cycles and pins
  input wire logic IO_WR_I,
  input wire logic SLEEP_N_I,
  input wire logic RX_BUS_ACTIVE_I,
  input wire logic AUX0_DEFAULT_N_I,
  input wire logic [SCPP_IO_ADDR_W-1:0] IO_ADDR_I,
  input wire logic [SCPP_IO_ADDR_W-1:0] IO_BASE_I,
  // Outputs
  input wire logic CHIP_RESET_O,
  input wire logic PARTIAL_RESET_O,
  input wire logic TXRX_INHIBIT_O,
  input wire logic HW_STANDBY_O,
  input wire logic HW_SUSPEND_O,
  input wire logic AUX_OUT0_PIN_N_O,
  input wire logic AUX_OUT1_PIN_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Writes during a chip reset are left out, since the forced value wins there
  logic sc_wr, w0, hit;
  assign sc_wr = WR_I && ADDR_I == SCPP_OFF_SELF_CONTROL && !CHIP_RESET_O;
  assign w0 = sc_wr && !WDATA_I[SCPP_BIT_CHIP_RESET];
  assign hit = IO_WR_I && IO_ADDR_I >= IO_BASE_I && IO_ADDR_I < IO_BASE_I + IO_SPAN;
  a_reset_start: assert property (sc_wr && WDATA_I[SCPP_BIT_CHIP_RESET] |=> CHIP_RESET_O && TXRX_INHIBIT_O)
    else $error("no reset");
  a_suspend_entry: assert property (w0 && WDATA_I[SCPP_BIT_SW_SUSPEND] |=> PARTIAL_RESET_O && TXRX_INHIBIT_O)
    else $error("no suspend");
  a_suspend_quiet: assert property (PARTIAL_RESET_O |-> TXRX_INHIBIT_O)
    else $error("traffic in suspend");
  a_io_wake: assert property (PARTIAL_RESET_O && hit && !WR_I ##1 !WR_I |=> !PARTIAL_RESET_O)
    else $error("no wake");
  a_aux1_pin: assert property (w0 ##1 !WR_I |=> AUX_OUT1_PIN_O ==
    ($past(WDATA_I[SCPP_BIT_AUX1_SEL], 2) ? $past(WDATA_I[SCPP_BIT_AUX1_LEVEL], 2) : $past(RX_BUS_ACTIVE_I)))
    else $error("aux1 wrong");
  a_aux0_pin: assert property (w0 ##1 !WR_I |=> AUX_OUT0_PIN_N_O ==
    ($past(WDATA_I[SCPP_BIT_AUX0_SEL], 2) ? !$past(WDATA_I[SCPP_BIT_AUX0_LEVEL], 2) : $past(AUX0_DEFAULT_N_I)))
    else $error("aux0 wrong");
  a_sleep_enter: assert property (w0 && WDATA_I[SCPP_BIT_SLEEP_EN] && !WDATA_I[SCPP_BIT_SW_SUSPEND] ##1
    !SLEEP_N_I && !WR_I |=> ($past(WDATA_I[SCPP_BIT_STANDBY_SEL], 2) ? HW_STANDBY_O : HW_SUSPEND_O))
    else $error("no sleep");
  a_sleep_cause: assert property (HW_STANDBY_O || HW_SUSPEND_O |->
    !$past(SLEEP_N_I) && !(HW_STANDBY_O && HW_SUSPEND_O)) else $error("bad sleep");
  c_chip_reset: cover property (CHIP_RESET_O);
  c_wake: cover property (PARTIAL_RESET_O ##1 !PARTIAL_RESET_O);
  c_standby: cover property (HW_STANDBY_O);
endmodule : scpp_sc_asserts

bind scpp_self_control scpp_sc_asserts #(.IO_SPAN(IO_SPAN)) u_sc_asserts (.*);

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import scpp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ee_ld = 1'b0, ee_pr = 1'b0;
  logic sleep_n = 1'b1, rx = 1'b1, a0_def = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, ee_val = 16'h0000, base = 16'h0300, rdata, io_addr;
  logic io_wr, crst, prst, inh, stby, susp, a0_n, a1;
  int bad_count = 0, total_checks = 0, n;
  localparam int RST_CYC = 2;
  always #2 clk = ~clk;
  scpp_isa_host u_host (.clk_i(clk), .io_wr_o(io_wr), .io_addr_o(io_addr));
  scpp_self_control #(.CHIP_RESET_CYC(RST_CYC)) DUT (.REF_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IO_WR_I(io_wr), .IO_ADDR_I(io_addr),
    .IO_BASE_I(base), .EE_LOAD_I(ee_ld), .EE_PRESENT_I(ee_pr), .EE_VALUE_I(ee_val), .SLEEP_N_I(sleep_n),
    .RX_BUS_ACTIVE_I(rx), .AUX0_DEFAULT_N_I(a0_def), .CHIP_RESET_O(crst), .PARTIAL_RESET_O(prst),
    .TXRX_INHIBIT_O(inh), .HW_STANDBY_O(stby), .HW_SUSPEND_O(susp), .AUX_OUT0_PIN_N_O(a0_n),
    .AUX_OUT1_PIN_O(a1));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask : chk
  // Read data stand for one cycle only, so they are compared right after the taking edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    if (!w) chk(rdata, d);
  endtask : acc
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : settle
  task automatic tally_and_finish();
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b0, 8'h00, 16'h0015);
    acc(1'b0, 8'h20, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      acc(1'b1, 8'h00, {i[3:0], 12'h000});
      settle(2);
      chk(a1, i[1] ? i[3] : rx);
      chk(a0_n, i[0] ? !i[2] : a0_def);
      acc(1'b0, 8'h00, {i[3:0], 12'h015});
      rx <= i[0];
      a0_def <= i[1];
    end
    acc(1'b1, 8'h00, 16'h3040);
    n = 0;
    repeat (8) begin
      n += (crst && inh);
      settle(1);
    end
    chk(16'(n), 16'(RST_CYC));
    acc(1'b0, 8'h00, 16'h0015);
    acc(1'b1, 8'h00, 16'h0100);
    settle(1);
    chk({prst, inh}, 2'b11);
    acc(1'b0, SCPP_OFF_MODE_STATUS, 16'h0001 << SCPP_ST_SW_SUSPEND);
    acc(1'b0, 8'h00, 16'h0115);
    u_host.io_write(base + 16'h0010);
    settle(3);
    chk(prst, 1'b1);
    u_host.io_write(base + 16'h000f);
    settle(2);
    chk({prst, inh}, 2'b00);
    sleep_n <= 1'b0;
    acc(1'b1, 8'h00, 16'h0600);
    settle(2);
    chk({stby, susp}, 2'b10);
    acc(1'b0, SCPP_OFF_MODE_STATUS, 16'h0001 << SCPP_ST_HW_STANDBY);
    acc(1'b1, 8'h00, 16'h0200);
    settle(2);
    chk({stby, susp}, 2'b01);
    acc(1'b0, SCPP_OFF_MODE_STATUS, 16'h0001 << SCPP_ST_HW_SUSPEND);
    acc(1'b1, 8'h00, 16'h0400);
    settle(2);
    chk({stby, susp}, 2'b00);
    sleep_n <= 1'b1;
    ee_pr <= 1'b1;
    ee_val <= 16'h3000;
    ee_ld <= 1'b1;
    settle(1);
    ee_ld <= 1'b0;
    acc(1'b0, 8'h00, 16'h3015);
    tally_and_finish();
  end
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : tb_top
